// >>> design/dbcc_pkg.sv
// Shared constants for the dual bridge chopper control block
package dbcc_pkg;
  localparam int WORD_BITS = 19;
  localparam int DATA_BITS = 18;
  // Word 0 field positions
  localparam int W0_DAC1_LSB = 1;
  localparam int W0_DAC2_LSB = 7;
  localparam int W0_PHASE1 = 13;
  localparam int W0_PHASE2 = 14;
  localparam int W0_MODE1 = 15;
  localparam int W0_MODE2 = 16;
  localparam int W0_REF_SEL = 17;
  localparam int W0_RANGE = 18;
  // Word 1 field positions
  localparam int W1_BLANK_LSB = 1;
  localparam int W1_OFF_LSB = 3;
  localparam int W1_FAST_LSB = 8;
  localparam int W1_OSC_LSB = 12;
  localparam int W1_SR_LSB = 14;
  localparam int W1_IDLE = 18;
  localparam logic [18:0] WORD_RESET = 19'h00000;
  // Rectification modes
  localparam logic [1:0] SR_ACTIVE = 2'h0;
  localparam logic [1:0] SR_DISABLED = 2'h1;
  localparam logic [1:0] SR_PASSIVE = 2'h2;
  localparam logic [1:0] SR_LOW_SIDE = 2'h3;
  // Timing source select
  localparam logic [1:0] OSC_INTERNAL = 2'h0;
  localparam logic [1:0] OSC_EXT_DIV1 = 2'h1;
  localparam logic [1:0] OSC_EXT_DIV2 = 2'h2;
  localparam logic [1:0] OSC_EXT_DIV4 = 2'h3;
  // Internal oscillator model: 4 MHz tick derived from the 10 MHz clock
  localparam int CLK_HZ = 10000000;
  localparam int INT_OSC_HZ = 4000000;
  localparam logic [15:0] INT_OSC_STEP = 16'(INT_OSC_HZ / 1000);
  localparam logic [15:0] INT_OSC_WRAP = 16'(CLK_HZ / 1000);
  localparam int OFF_MULT = 8;
  localparam logic [8:0] BLANK_T0 = 9'h004;
  localparam logic [8:0] BLANK_T1 = 9'h006;
  localparam logic [8:0] BLANK_T2 = 9'h008;
  localparam logic [8:0] BLANK_T3 = 9'h00C;
  typedef enum logic [1:0] {DBCC_ON, DBCC_FAST, DBCC_SLOW} dbcc_pwm_t;
endpackage

// >>> design/dbcc_bridge.sv
// One bridge: fixed off-time chopper with decay and rectification steering
`timescale 1ns/1ps
`default_nettype none
module dbcc_bridge (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Settings
  input wire logic enable_in,
  input wire logic [5:0] code_in,
  input wire logic phase_in,
  input wire logic slow_mode_in,
  input wire logic [4:0] off_n_in,
  input wire logic [3:0] fast_n_in,
  input wire logic [1:0] blank_sel_in,
  input wire logic [1:0] sr_mode_in,
  // Timing and sense
  input wire logic tick_in,
  input wire logic trip_in,
  input wire logic zero_in,
  input wire logic rev_limit_in,
  // Gate drives: source and sink, A and B legs; off and fast status
  output logic src_a_out,
  output logic src_b_out,
  output logic snk_a_out,
  output logic snk_b_out,
  output logic off_out,
  output logic fast_out
);
  import dbcc_pkg::*;
  dbcc_pwm_t st_q, st_d;
  logic [8:0] cnt_q, cnt_d, blank_q, blank_d;
  logic phase_q, sr_cut_q, sr_cut_d;
  logic [8:0] t_off, t_fd, t_blank;
  logic drv_src, drv_snk, rect;

  function automatic logic [8:0] dur(input logic [4:0] n);
    dur = 9'((9'(n) + 9'h001) * 9'(OFF_MULT) - 9'h001);
  endfunction

  always_comb begin
    t_off = dur(off_n_in);
    t_fd = dur({1'b0, fast_n_in});
    case (blank_sel_in)
      2'h0: t_blank = BLANK_T0;
      2'h1: t_blank = BLANK_T1;
      2'h2: t_blank = BLANK_T2;
      default: t_blank = BLANK_T3;
    endcase
    st_d = st_q;
    cnt_d = cnt_q;
    blank_d = blank_q;
    sr_cut_d = sr_cut_q;
    if (phase_in != phase_q) begin
      blank_d = t_blank;
    end else if (tick_in && blank_q != 9'h000) begin
      blank_d = blank_q - 9'h001;
    end
    case (st_q)
      DBCC_ON: begin
        // Off cycle on disable command or current trip
        if (!enable_in || (trip_in && blank_q == 9'h000)) begin
          cnt_d = 9'h000;
          sr_cut_d = 1'b0;
          st_d = (slow_mode_in) ? DBCC_SLOW : DBCC_FAST;
        end
      end
      DBCC_FAST, DBCC_SLOW: begin
        if (tick_in) begin
          cnt_d = cnt_q + 9'h001;
          if (cnt_q >= t_off) begin
            st_d = DBCC_ON;
            blank_d = t_blank;
          end else if (st_q == DBCC_FAST && cnt_q >= t_fd) begin
            st_d = DBCC_SLOW;
          end
        end
        if (sr_mode_in == SR_ACTIVE && zero_in) begin
          sr_cut_d = 1'b1;
        end
        if (sr_mode_in == SR_PASSIVE && rev_limit_in) begin
          sr_cut_d = 1'b1;
        end
      end
      default: st_d = DBCC_ON;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= DBCC_ON;
      cnt_q <= 9'h000;
      blank_q <= 9'h000;
      phase_q <= 1'b0;
      sr_cut_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      blank_q <= blank_d;
      phase_q <= phase_in;
      sr_cut_q <= sr_cut_d;
    end
  end

  always_comb begin
    // Rectifier may conduct only in a mode that switches and before a cut
    rect = (sr_mode_in != SR_DISABLED) && !sr_cut_q;
    drv_src = 1'b0;
    drv_snk = 1'b0;
    src_a_out = 1'b0;
    src_b_out = 1'b0;
    snk_a_out = 1'b0;
    snk_b_out = 1'b0;
    if (enable_in && code_in != 6'h00) begin
      case (st_q)
        DBCC_ON: begin
          src_a_out = phase_in;
          snk_b_out = phase_in;
          src_b_out = !phase_in;
          snk_a_out = !phase_in;
        end
        DBCC_SLOW: begin
          if (sr_mode_in == SR_LOW_SIDE) begin
            // Source side chopped, both low sides short the loop
            snk_a_out = 1'b1;
            snk_b_out = 1'b1;
          end else begin
            // Source side chopped, sink keeps conducting
            snk_a_out = !phase_in;
            snk_b_out = phase_in;
            drv_snk = rect;
            snk_a_out = snk_a_out | (drv_snk & phase_in);
            snk_b_out = snk_b_out | (drv_snk & !phase_in);
          end
        end
        DBCC_FAST: begin
          // Opposite devices rectify when allowed; in low-side mode only the sinks do
          drv_src = rect && sr_mode_in != SR_LOW_SIDE;
          drv_snk = rect;
          src_b_out = drv_src & phase_in;
          src_a_out = drv_src & !phase_in;
          snk_a_out = drv_snk & phase_in;
          snk_b_out = drv_snk & !phase_in;
        end
        default: ;
      endcase
    end
  end

  assign off_out = (st_q != DBCC_ON);
  assign fast_out = (st_q == DBCC_FAST);

  property p_off_len;
    @(posedge clk_in) disable iff (!rst_n_in)
      (st_q != DBCC_ON) |-> (cnt_q <= t_off + 9'h001);
  endproperty
  a_off_len: assert property (p_off_len) else $error("off period overran");

  property p_zero_off;
    @(posedge clk_in) disable iff (!rst_n_in)
      (code_in == 6'h00) |-> !(src_a_out | src_b_out | snk_a_out | snk_b_out);
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero code drove bridge");

  property p_low_side;
    @(posedge clk_in) disable iff (!rst_n_in)
      (sr_mode_in == SR_LOW_SIDE && st_q != DBCC_ON) |-> !(src_a_out | src_b_out);
  endproperty
  a_low_side: assert property (p_low_side) else $error("high side rectified");

  property p_sr_dis;
    @(posedge clk_in) disable iff (!rst_n_in)
      (sr_mode_in == SR_DISABLED && st_q == DBCC_FAST) |-> !(src_a_out | src_b_out | snk_a_out | snk_b_out);
  endproperty
  a_sr_dis: assert property (p_sr_dis) else $error("switching while disabled");

  sequence s_fast_end;
    tick_in && st_q == DBCC_FAST && cnt_q >= t_fd && cnt_q < t_off;
  endsequence
  property p_mixed;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_fast_end |=> (st_q == DBCC_SLOW);
  endproperty
  a_mixed: assert property (p_mixed) else $error("fast decay did not end");

  property p_blank;
    @(posedge clk_in) disable iff (!rst_n_in)
      (phase_in != phase_q) |=> (blank_q == $past(t_blank));
  endproperty
  a_blank: assert property (p_blank) else $error("blank not restarted");
endmodule
`default_nettype wire

// >>> design/dbcc_top.sv
// Serial port, protection and timing source for the dual bridge chopper
`timescale 1ns/1ps
`default_nettype none
module dbcc_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Serial port
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  input wire logic strobe_n_in,
  // Protection and power
  input wire logic sleep_n_in,
  input wire logic supply_undervoltage_lockout_in,
  input wire logic gate_supply_fault_in,
  input wire logic pump_supply_low_in,
  input wire logic over_temp_in,
  // Timing pin
  input wire logic ext_osc_in,
  // Sense comparators per bridge
  input wire logic [1:0] trip_in,
  input wire logic [1:0] zero_in,
  input wire logic [1:0] rev_limit_in,
  // Bridge gate drives
  output logic [1:0] src_a_out,
  output logic [1:0] src_b_out,
  output logic [1:0] snk_a_out,
  output logic [1:0] snk_b_out,
  // Status and analog settings
  output logic [1:0] off_out,
  output logic [1:0] fast_out,
  output logic [6:0] thr1_out,
  output logic [6:0] thr2_out,
  output logic ext_ref_out,
  output logic range4_out,
  output logic pump_on_out
);
  import dbcc_pkg::*;
  logic rst_s1_q, rst_s2_q;
  logic [18:0] shift_q, shift_d, word0_q, word0_d, word1_q, word1_d;
  logic sck_q, sck_d, stb_q, stb_d;
  logic xo_q, xo_d;
  logic [1:0] xdiv_q, xdiv_d;
  logic [15:0] acc_q, acc_d;
  logic tick;
  logic clear, kill;
  logic [1:0] b_en;
  logic [1:0] b_sa, b_sb, b_ka, b_kb, b_off, b_fast;
  logic [1:0] osc_sel;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign clear = !sleep_n_in || supply_undervoltage_lockout_in;
  assign kill = clear || gate_supply_fault_in || pump_supply_low_in || over_temp_in
                || !word1_q[W1_IDLE];

  // Serial shift and load
  always_comb begin
    shift_d = shift_q;
    word0_d = word0_q;
    word1_d = word1_q;
    sck_d = ser_clk_in;
    stb_d = strobe_n_in;
    if (ser_clk_in && !sck_q) begin
      shift_d = {shift_q[17:0], ser_data_in};
    end
    if (strobe_n_in && !stb_q) begin
      if (shift_q[0]) begin
        word1_d = shift_q;
      end else begin
        word0_d = shift_q;
      end
    end
    if (clear) begin
      shift_d = WORD_RESET;
      word0_d = WORD_RESET;
      word1_d = WORD_RESET;
    end
  end

  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      shift_q <= WORD_RESET;
      word0_q <= WORD_RESET;
      word1_q <= WORD_RESET;
      sck_q <= 1'b0;
      stb_q <= 1'b1;
    end else begin
      shift_q <= shift_d;
      word0_q <= word0_d;
      word1_q <= word1_d;
      sck_q <= sck_d;
      stb_q <= stb_d;
    end
  end

  // Timing tick source
  assign osc_sel = word1_q[W1_OSC_LSB +: 2];
  always_comb begin
    xo_d = ext_osc_in;
    xdiv_d = xdiv_q;
    acc_d = acc_q;
    tick = 1'b0;
    if (osc_sel == OSC_INTERNAL) begin
      if (acc_q + INT_OSC_STEP >= INT_OSC_WRAP) begin
        acc_d = acc_q + INT_OSC_STEP - INT_OSC_WRAP;
        tick = 1'b1;
      end else begin
        acc_d = acc_q + INT_OSC_STEP;
      end
    end else if (ext_osc_in && !xo_q) begin
      xdiv_d = xdiv_q + 2'h1;
      case (osc_sel)
        OSC_EXT_DIV1: tick = 1'b1;
        OSC_EXT_DIV2: tick = xdiv_q[0];
        default: tick = (xdiv_q == 2'h3);
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      xo_q <= 1'b0;
      xdiv_q <= 2'h0;
      acc_q <= 16'h0000;
    end else begin
      xo_q <= xo_d;
      xdiv_q <= xdiv_d;
      acc_q <= acc_d;
    end
  end

  assign b_en[0] = !kill && word0_q[W0_DAC1_LSB +: 6] != 6'h00;
  assign b_en[1] = !kill && word0_q[W0_DAC2_LSB +: 6] != 6'h00;

  dbcc_bridge u_br1 (
    .clk_in(clk_in), .rst_n_in(rst_s2_q), .enable_in(b_en[0]),
    .code_in(word0_q[W0_DAC1_LSB +: 6]), .phase_in(word0_q[W0_PHASE1]),
    .slow_mode_in(word0_q[W0_MODE1]), .off_n_in(word1_q[W1_OFF_LSB +: 5]),
    .fast_n_in(word1_q[W1_FAST_LSB +: 4]), .blank_sel_in(word1_q[W1_BLANK_LSB +: 2]),
    .sr_mode_in(word1_q[W1_SR_LSB +: 2]), .tick_in(tick), .trip_in(trip_in[0]),
    .zero_in(zero_in[0]), .rev_limit_in(rev_limit_in[0]),
    .src_a_out(b_sa[0]), .src_b_out(b_sb[0]), .snk_a_out(b_ka[0]), .snk_b_out(b_kb[0]),
    .off_out(b_off[0]), .fast_out(b_fast[0])
  );
  dbcc_bridge u_br2 (
    .clk_in(clk_in), .rst_n_in(rst_s2_q), .enable_in(b_en[1]),
    .code_in(word0_q[W0_DAC2_LSB +: 6]), .phase_in(word0_q[W0_PHASE2]),
    .slow_mode_in(word0_q[W0_MODE2]), .off_n_in(word1_q[W1_OFF_LSB +: 5]),
    .fast_n_in(word1_q[W1_FAST_LSB +: 4]), .blank_sel_in(word1_q[W1_BLANK_LSB +: 2]),
    .sr_mode_in(word1_q[W1_SR_LSB +: 2]), .tick_in(tick), .trip_in(trip_in[1]),
    .zero_in(zero_in[1]), .rev_limit_in(rev_limit_in[1]),
    .src_a_out(b_sa[1]), .src_b_out(b_sb[1]), .snk_a_out(b_ka[1]), .snk_b_out(b_kb[1]),
    .off_out(b_off[1]), .fast_out(b_fast[1])
  );

  // Registered outputs; kill also gates here for a same-cycle cut
  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      src_a_out <= 2'h0;
      src_b_out <= 2'h0;
      snk_a_out <= 2'h0;
      snk_b_out <= 2'h0;
      off_out <= 2'h0;
      fast_out <= 2'h0;
      thr1_out <= 7'h00;
      thr2_out <= 7'h00;
      ext_ref_out <= 1'b0;
      range4_out <= 1'b0;
      pump_on_out <= 1'b0;
    end else begin
      src_a_out <= kill ? 2'h0 : b_sa;
      src_b_out <= kill ? 2'h0 : b_sb;
      snk_a_out <= kill ? 2'h0 : b_ka;
      snk_b_out <= kill ? 2'h0 : b_kb;
      off_out <= b_off;
      fast_out <= b_fast;
      // Threshold numerator over 64 of the reference
      thr1_out <= 7'(word0_q[W0_DAC1_LSB +: 6]) + 7'h01;
      thr2_out <= 7'(word0_q[W0_DAC2_LSB +: 6]) + 7'h01;
      ext_ref_out <= word0_q[W0_REF_SEL];
      range4_out <= word0_q[W0_RANGE];
      pump_on_out <= word1_q[W1_IDLE] && !clear;
    end
  end

  property p_kill;
    @(posedge clk_in) disable iff (!rst_s2_q)
      kill |=> (src_a_out == 2'h0 && src_b_out == 2'h0 && snk_a_out == 2'h0 && snk_b_out == 2'h0);
  endproperty
  a_kill: assert property (p_kill) else $error("outputs live during fault");

  property p_clear;
    @(posedge clk_in) disable iff (!rst_s2_q)
      clear |=> (word0_q == WORD_RESET && word1_q == WORD_RESET);
  endproperty
  a_clear: assert property (p_clear) else $error("port not cleared");

  sequence s_strobe_rise;
    strobe_n_in && !stb_q && !clear;
  endsequence
  property p_load;
    @(posedge clk_in) disable iff (!rst_s2_q)
      s_strobe_rise |=> ($past(shift_q[0]) ? word1_q == $past(shift_q) : word0_q == $past(shift_q));
  endproperty
  a_load: assert property (p_load) else $error("word not loaded");

  property p_shift;
    @(posedge clk_in) disable iff (!rst_s2_q)
      (ser_clk_in && !sck_q && !clear) |=> (shift_q[0] == $past(ser_data_in));
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted");

  property p_thr;
    @(posedge clk_in) disable iff (!rst_s2_q)
      rst_s2_q |=> (thr1_out == 7'($past(word0_q[W0_DAC1_LSB +: 6])) + 7'h01);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold wrong");

  property p_thr2;
    @(posedge clk_in) disable iff (!rst_s2_q)
      rst_s2_q |=> (thr2_out == 7'($past(word0_q[W0_DAC2_LSB +: 6])) + 7'h01);
  endproperty
  a_thr2: assert property (p_thr2) else $error("threshold two wrong");

  property p_range;
    @(posedge clk_in) disable iff (!rst_s2_q)
      rst_s2_q |=> (range4_out == $past(word0_q[W0_RANGE]));
  endproperty
  a_range: assert property (p_range) else $error("range select not followed");

  property p_int_gap;
    @(posedge clk_in) disable iff (!rst_s2_q)
      (osc_sel == OSC_INTERNAL && tick) |=> !(osc_sel == OSC_INTERNAL && tick);
  endproperty
  a_int_gap: assert property (p_int_gap) else $error("internal tick too fast");

  sequence s_int_run;
    (osc_sel == OSC_INTERNAL) [*3];
  endsequence
  property p_int_min;
    @(posedge clk_in) disable iff (!rst_s2_q)
      s_int_run |-> (tick || $past(tick) || $past(tick, 2));
  endproperty
  a_int_min: assert property (p_int_min) else $error("internal tick too slow");

  property p_ext_edge;
    @(posedge clk_in) disable iff (!rst_s2_q)
      (osc_sel != OSC_INTERNAL && tick) |-> (ext_osc_in && !xo_q);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("tick without external edge");

  property p_sleep;
    @(posedge clk_in) disable iff (!rst_s2_q)
      !sleep_n_in |=> (!pump_on_out && (src_a_out | src_b_out | snk_a_out | snk_b_out) == 2'h0);
  endproperty
  a_sleep: assert property (p_sleep) else $error("active while asleep");

  property p_supply_undervoltage_lockout;
    @(posedge clk_in) disable iff (!rst_s2_q)
      supply_undervoltage_lockout_in |=> (shift_q == WORD_RESET);
  endproperty
  a_supply_undervoltage_lockout: assert property (p_supply_undervoltage_lockout) else $error("shift not cleared in lockout");

  property p_hold;
    @(posedge clk_in) disable iff (!rst_s2_q)
      (!(strobe_n_in && !stb_q) && !clear) |=> ($stable(word0_q) && $stable(word1_q));
  endproperty
  a_hold: assert property (p_hold) else $error("word changed without strobe");
endmodule
`default_nettype wire

// >>> verification/dbcc_host.sv
// Host model that writes words over the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module dbcc_host (
  // Clock
  input wire logic clk_in,
  // Serial port
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic strobe_n_out
);
  initial begin
    ser_clk_out = 1'h0;
    ser_data_out = 1'h0;
    strobe_n_out = 1'h1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // One word, top data bit first, select bit last
  task automatic send_word(input logic [18:0] w);
    strobe_n_out = 1'h0;
    for (int i = 18; i >= 0; i--) begin
      ser_data_out = w[i];
      hold(2);
      ser_clk_out = 1'h1;
      hold(2);
      ser_clk_out = 1'h0;
    end
    hold(2);
    strobe_n_out = 1'h1;
    // Data line released: show inverse of last bit
    ser_data_out = ~w[0];
    hold(2);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_dbcc_top.sv
// Self-checking bench for the dual bridge chopper control block
`timescale 1ns/1ps
`default_nettype none
module tb_dbcc_top;
  import dbcc_pkg::*;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic ser_clk, ser_data, strobe_n;
  logic sleep_n = 1'h1;
  logic lockout = 1'h0;
  logic [2:0] flt = 3'h0;
  logic ext_osc = 1'h0;
  logic [1:0] trip = 2'h0;
  logic [1:0] zero = 2'h0;
  logic [1:0] rev = 2'h0;
  logic [1:0] src_a, src_b, snk_a, snk_b, off, fast;
  logic [6:0] thr1, thr2;
  logic ext_ref, range4, pump_on;
  logic [18:0] w0n, w1n;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int off_n, fast_n;
  int p10[4] = '{25, 40, 80, 160};
  logic [1:0] srm[4] = '{SR_DISABLED, SR_LOW_SIDE, SR_ACTIVE, SR_PASSIVE};
  logic [3:0] sexp[4] = '{4'h1, 4'h3, 4'h1, 4'h1};
  always #50 clk_in = ~clk_in;
  // Free-running external timing clock, four system cycles a period
  always #200 ext_osc = ~ext_osc;
  dbcc_host i_host (.clk_in(clk_in), .ser_clk_out(ser_clk), .ser_data_out(ser_data),
    .strobe_n_out(strobe_n));
  dbcc_top i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ser_clk_in(ser_clk),
    .ser_data_in(ser_data), .strobe_n_in(strobe_n), .sleep_n_in(sleep_n),
    .supply_undervoltage_lockout_in(lockout), .gate_supply_fault_in(flt[0]),
    .pump_supply_low_in(flt[1]), .over_temp_in(flt[2]), .ext_osc_in(ext_osc),
    .trip_in(trip), .zero_in(zero), .rev_limit_in(rev), .src_a_out(src_a),
    .src_b_out(src_b), .snk_a_out(snk_a), .snk_b_out(snk_b), .off_out(off),
    .fast_out(fast), .thr1_out(thr1), .thr2_out(thr2), .ext_ref_out(ext_ref),
    .range4_out(range4), .pump_on_out(pump_on));
  function automatic logic [18:0] mk0(logic [5:0] c1, logic [5:0] c2, logic ph1, logic m1,
    logic rng);
    return {rng, 1'h1, 1'h0, m1, 1'h0, ph1, c2, c1, 1'h0};
  endfunction
  function automatic logic [18:0] mk1(logic [4:0] offn, logic [3:0] fd, logic [1:0] osc,
    logic [1:0] sr);
    return {1'h1, 2'h0, sr, osc, fd, offn, 2'h0, 1'h1};
  endfunction
  function automatic logic [3:0] drv(int i);
    return {src_a[i], src_b[i], snk_a[i], snk_b[i]};
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic cfg(input logic [18:0] a, input logic [18:0] b);
    i_host.send_word(a);
    i_host.send_word(b);
    wait_n(80);
  endtask
  // Trip bridge 1 once blanking is over, release when off starts
  task automatic trip_start();
    int k;
    k = 0;
    wait_n(80);
    trip[0] = 1'h1;
    while (off[0] !== 1'h1 && k < 100) begin
      wait_n(1);
      k++;
    end
    trip[0] = 1'h0;
  endtask
  task automatic pulse_off(output int on, output int fn);
    on = 0;
    fn = 0;
    trip_start();
    while (off[0] === 1'h1 && on < 900) begin
      on++;
      if (fast[0] === 1'h1) fn++;
      wait_n(1);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    w0n = mk0(6'h05, 6'h3F, 1'h1, 1'h0, 1'h1);
    w1n = mk1(5'h01, 4'h0, OSC_INTERNAL, SR_ACTIVE);
    wait_n(4);
    rst_n_in = 1'h1;
    wait_n(5);
    chk("thr1_rst", 8'h01, {1'h0, thr1});
    chk("drv_rst", 8'h00, {drv(0), drv(1)});
    chk("pump_rst", 8'h00, {7'h0, pump_on});
    cfg(w0n, w1n);
    chk("thr1", 8'h06, {1'h0, thr1});
    chk("thr2", 8'h40, {1'h0, thr2});
    chk("ext_ref", 8'h01, {7'h0, ext_ref});
    chk("range4", 8'h01, {7'h0, range4});
    chk("pump", 8'h01, {7'h0, pump_on});
    chk("drv1_ph1", 8'h09, {4'h0, drv(0)});
    cfg(mk0(6'h05, 6'h00, 1'h0, 1'h0, 1'h0), w1n);
    chk("range8", 8'h00, {7'h0, range4});
    chk("drv1_ph0", 8'h06, {4'h0, drv(0)});
    chk("drv2_zero", 8'h00, {4'h0, drv(1)});
    for (int i = 0; i < 4; i++) begin
      cfg(w0n, mk1(5'h01, 4'h0, 2'(i), SR_ACTIVE));
      pulse_off(off_n, fast_n);
      chk_rng("off_len", 15 * p10[i] / 10 - 2, 17 * p10[i] / 10 + 2, off_n);
      chk_rng("fast_len", 7 * p10[i] / 10 - 2, 9 * p10[i] / 10 + 2, fast_n);
    end
    cfg(w0n, mk1(5'h01, 4'hF, OSC_INTERNAL, SR_ACTIVE));
    pulse_off(off_n, fast_n);
    chk_rng("fast_all", off_n, off_n, fast_n);
    for (int i = 0; i < 4; i++) begin
      cfg(mk0(6'h05, 6'h3F, 1'h1, 1'h1, 1'h1), mk1(5'h01, 4'h0, OSC_INTERNAL, srm[i]));
      trip_start();
      zero[0] = (srm[i] == SR_ACTIVE);
      rev[0] = (srm[i] == SR_PASSIVE);
      wait_n(4);
      chk("sr_drv", {4'h0, sexp[i]}, {4'h0, drv(0)});
      zero = 2'h0;
      rev = 2'h0;
      wait_n(60);
    end
    cfg(w0n, w1n);
    for (int i = 0; i < 3; i++) begin
      flt = 3'(1 << i);
      wait_n(4);
      chk("flt_drv", 8'h00, {drv(0), drv(1)});
      flt = 3'h0;
      wait_n(80);
      chk("flt_back", 8'h09, {4'h0, drv(0)});
    end
    for (int i = 0; i < 2; i++) begin
      cfg(w0n, w1n);
      sleep_n = (i != 0);
      lockout = (i != 0);
      wait_n(4);
      chk("clr_thr1", 8'h01, {1'h0, thr1});
      chk("clr_pump", 8'h00, {7'h0, pump_on});
      chk("clr_drv", 8'h00, {drv(0), drv(1)});
      sleep_n = 1'h1;
      lockout = 1'h0;
      wait_n(4);
      chk("kept_clr", 8'h01, {1'h0, thr1});
    end
    complete_run();
  end
endmodule
`default_nettype wire
